// [wdos_core.sv]
// watchdog and oscillator-stabilisation timer: base timer, guard counter, register port
// assumes one system clock; ring oscillator arrives as a slow level on i_ring_osc
`timescale 1ns/1ps
module wdos_core
  import wdos_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  input  wire wdos_pkg::wdos_bus_t i_bus,
  input  wire logic [7:0]        i_option_byte,
  input  wire logic              i_ring_osc,
  input  wire logic              i_stop_mode,
  input  wire logic              i_idle_mode,
  input  wire logic              i_ext_wake,
  output logic [7:0]             o_rdata,
  output logic                   o_wd_reset,
  output logic                   o_cpu_clock_en,
  output logic                   o_ring_osc_en,
  output logic                   o_base_overflow_tick
);
  import wdos_pkg::*;

  wdos_regs_t state_reg;
  wdos_regs_t state_next;

  // refuse overflow taps that the guard counter cannot hold
  if (WDOS_TICK_OVF_BIT > 7)
  begin : g_bad_tick_bit
    $error("tick overflow bit outside the guard counter");
  end
  if (WDOS_RING_OVF_BIT > 7)
  begin : g_bad_ring_bit
    $error("ring overflow bit outside the guard counter");
  end
  // stabilisation and tick taps are decoded as a full low nibble
  if (WDOS_STAB_OVF_BIT != 3 || WDOS_TICK_OVF_BIT != 3)
  begin : g_bad_nibble_tap
    $error("nibble overflow taps must be bit 3");
  end
  // both action bits self-clear as the low two bits of the control register
  if (WDOS_CLR_BIT > 1 || WDOS_DIVCLR_BIT > 1 || WDOS_CLR_BIT == WDOS_DIVCLR_BIT)
  begin : g_bad_action_bits
    $error("action bits must be bits 1 and 0");
  end
  // reset rate must be the slowest divider setting
  if (WDOS_DIV_4096_MAX <= WDOS_DIV_1024_MAX || WDOS_DIV_1024_MAX <= WDOS_DIV_128_MAX)
  begin : g_bad_div_order
    $error("divider ceilings out of order");
  end

  // signature code test, shared by both control registers
  function automatic logic is_signature(input logic [3:0] nib);
    is_signature = (nib == WDOS_SIGNATURE);
  endfunction

  // low nibble all ones: the next increment carries out of bit 3
  function automatic logic nibble_full(input logic [7:0] value);
    nibble_full = (value[3:0] == 4'hf);
  endfunction

  // 8-bit increment with the carry kept in bit 8
  function automatic logic [8:0] inc_carry(input logic [7:0] value);
    inc_carry = {1'b0, value} + 9'h001;
  endfunction

  // divider ceiling for base_timer_control[3:2]
  function automatic logic [11:0] div_max(input logic [1:0] sel);
    unique case (sel)
      2'b00:   div_max = WDOS_DIV_4096_MAX;
      2'b01:   div_max = WDOS_DIV_1024_MAX;
      2'b10:   div_max = WDOS_DIV_128_MAX;
      default: div_max = WDOS_DIV_16_MAX;
    endcase
  endfunction

  logic       wr_base;
  logic       wr_guard;
  logic       sw_clear;
  logic       div_tick;
  logic       base_ovf;
  logic       ring_mode;
  logic       ring_stop;
  logic       ring_edge;
  logic       guard_tick;
  logic       guard_ovf;
  logic       low_power;
  logic [8:0] guard_sum;
  logic [8:0] base_sum;
  logic [11:0] div_limit;
  logic       div_clear;
  logic       wd_enabled;
  logic       stab_done;
  logic       enter_stop;
  logic       wake_req;

  always_comb
  begin
    state_next = state_reg;
    wr_base    = i_bus.wr && (i_bus.addr == WDOS_ADDR_BASE_CTRL);
    wr_guard   = i_bus.wr && (i_bus.addr == WDOS_ADDR_GUARD_CTRL);
    sw_clear   = (wr_base && i_bus.wdata[WDOS_CLR_BIT])
              || (wr_guard && is_signature(i_bus.wdata[3:0]));
    div_clear  = wr_base && i_bus.wdata[WDOS_DIVCLR_BIT];
    div_limit  = div_max(state_reg.base_ctrl[3:2]);
    ring_mode  = i_option_byte[7];
    ring_stop  = ring_mode && is_signature(state_reg.guard_ctrl[7:4]);
    wd_enabled = !is_signature(state_reg.base_ctrl[7:4]);
    // stop only taken from run; a wake outside stop is ignored
    enter_stop = (state_reg.state == WDOS_ST_RUN) && i_stop_mode;
    wake_req   = (state_reg.state == WDOS_ST_STOP) && i_ext_wake;
    low_power  = i_stop_mode || i_idle_mode;
    ring_edge  = state_reg.ring_sync2 && !state_reg.ring_prev;

    // register writes; action bits self-clear
    if (wr_base)
    begin
      state_next.base_ctrl = {i_bus.wdata[7:2], 2'b00};
    end
    if (wr_guard)
    begin
      state_next.guard_ctrl = {i_bus.wdata[7:4], 4'h0};
    end

    // prescaler; runs except during stop
    div_tick = 1'b0;
    if (state_reg.state == WDOS_ST_STOP)
    begin
      state_next.divider = state_reg.divider;
    end
    else if (div_clear)
    begin
      state_next.divider = 12'h000;
    end
    // /4096 selected at reset
    // >= so a smaller ceiling written mid-count wraps at once
    else if (state_reg.divider >= div_limit)
    begin
      state_next.divider = 12'h000;
      div_tick           = 1'b1;
    end
    else
    begin
      state_next.divider = state_reg.divider + 12'h001;
    end

    base_sum = inc_carry(state_reg.base_count);
    // software clear wins over the tick
    base_ovf = div_tick && base_sum[8];
    if (sw_clear)
    begin
      state_next.base_count = 8'h00;
    end
    else if (div_tick)
    begin
      state_next.base_count = base_sum[7:0];
    end

    guard_tick = ring_mode ? ring_edge : base_ovf;
    guard_sum  = inc_carry(state_reg.guard_count);
    guard_ovf  = guard_tick && (ring_mode
               ? guard_sum[WDOS_RING_OVF_BIT + 1]
               : nibble_full(state_reg.guard_count));
    // clear wins over the sleep clear and the increment
    if (sw_clear)
    begin
      state_next.guard_count = 8'h00;
    end
    else if (ring_stop && low_power)
    begin
      state_next.guard_count = 8'h00;
    end
    else if (guard_tick)
    begin
      state_next.guard_count = guard_sum[7:0];
    end

    if (wd_enabled && guard_ovf)
    begin
      state_next.wd_reset = 1'b1;
    end
    else
    begin
      state_next.wd_reset = 1'b0;
    end

    // gate cpu until bit 3 carry
    stab_done = div_tick && nibble_full(state_reg.base_count);
    unique case (state_reg.state)
      WDOS_ST_STAB:
      begin
        // cpu stays gated until the bit 3 carry
        if (stab_done)
        begin
          state_next.state = WDOS_ST_RUN;
        end
      end
      WDOS_ST_RUN:
      begin
        if (enter_stop)
        begin
          state_next.state = WDOS_ST_STOP;
        end
      end
      WDOS_ST_STOP:
      begin
        // divider stays frozen; counting resumes at the programmed rate
        if (wake_req)
        begin
          state_next.state      = WDOS_ST_STAB;
          state_next.base_count = 8'h00;
        end
      end
    endcase

    // two flops: the ring oscillator is unrelated to i_clock
    state_next.ring_sync1 = i_ring_osc;
    state_next.ring_sync2 = state_reg.ring_sync1;
    state_next.ring_prev  = state_reg.ring_sync2;

    // read data follows the address one cycle later
    if (i_bus.addr == WDOS_ADDR_BASE_CTRL)
    begin
      state_next.rdata = state_reg.base_ctrl;
    end
    else if (i_bus.addr == WDOS_ADDR_GUARD_CTRL)
    begin
      state_next.rdata = state_reg.guard_ctrl;
    end
    else if (i_bus.addr == WDOS_ADDR_BASE_COUNT)
    begin
      state_next.rdata = state_reg.base_count;
    end
    else
    begin
      state_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      state_reg             <= '0;
      state_reg.state       <= WDOS_ST_STAB;
      state_reg.base_ctrl   <= WDOS_BASE_CTRL_RST;
      state_reg.guard_ctrl  <= WDOS_GUARD_CTRL_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_rdata              = state_reg.rdata;
  assign o_wd_reset           = state_reg.wd_reset;
  assign o_cpu_clock_en       = (state_reg.state == WDOS_ST_RUN);
  // combinational so the ring stops in the first sleep cycle
  assign o_ring_osc_en        = !(ring_stop && low_power);
  assign o_base_overflow_tick = base_ovf;

endmodule // wdos_core

// [wdos_pkg.sv]
// package for the watchdog and oscillation-stabilisation block
// assumes an 8-bit register port inside the microcontroller core
package wdos_pkg;
  localparam logic [7:0] WDOS_ADDR_BASE_CTRL  = 8'hd3;
  localparam logic [7:0] WDOS_ADDR_BASE_COUNT = 8'hfd;
  localparam logic [7:0] WDOS_ADDR_GUARD_CTRL = 8'hf2;
  localparam logic [7:0] WDOS_BASE_CTRL_RST   = 8'h00;
  localparam logic [7:0] WDOS_GUARD_CTRL_RST  = 8'h00;
  localparam logic [3:0] WDOS_SIGNATURE       = 4'ha;
  localparam int         WDOS_CLR_BIT         = 1;
  localparam int         WDOS_DIVCLR_BIT      = 0;
  localparam int         WDOS_TICK_OVF_BIT    = 3;
  localparam int         WDOS_RING_OVF_BIT    = 7;
  localparam int         WDOS_STAB_OVF_BIT    = 3;
  localparam logic [11:0] WDOS_DIV_4096_MAX   = 12'hfff;
  localparam logic [11:0] WDOS_DIV_1024_MAX   = 12'h3ff;
  localparam logic [11:0] WDOS_DIV_128_MAX    = 12'h07f;
  localparam logic [11:0] WDOS_DIV_16_MAX     = 12'h00f;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdos_bus_t;

  typedef enum logic [2:0] {
    WDOS_ST_STAB = 3'b001,
    WDOS_ST_RUN  = 3'b010,
    WDOS_ST_STOP = 3'b100
  } wdos_state_t;

  typedef struct packed {
    wdos_state_t state;
    logic [7:0]  base_ctrl;
    logic [7:0]  guard_ctrl;
    logic [7:0]  base_count;
    logic [7:0]  guard_count;
    logic [11:0] divider;
    logic        ring_sync1;
    logic        ring_sync2;
    logic        ring_prev;
    logic        wd_reset;
    logic [7:0]  rdata;
  } wdos_regs_t;
endpackage

// [wdos_core_sva.sv]
// assertions on the wdos_core ports
// assumes the bind at the foot of this file
`timescale 1ns/1ps
module wdos_core_sva
  import wdos_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_reset_n,
  input wire wdos_pkg::wdos_bus_t i_bus,
  input wire logic [7:0]          i_option_byte,
  input wire logic                i_stop_mode,
  input wire logic                i_idle_mode,
  input wire logic [7:0]          o_rdata,
  input wire logic                o_wd_reset,
  input wire logic                o_cpu_clock_en,
  input wire logic                o_ring_osc_en
);
  logic wd_off;
  logic ring_off;
  logic sleep;
  assign sleep = i_stop_mode | i_idle_mode;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // shadows of both signature fields
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      wd_off   <= 1'b0;
      ring_off <= 1'b0;
    end
    else if (i_bus.wr)
    begin
      if (i_bus.addr == WDOS_ADDR_BASE_CTRL)
        wd_off <= (i_bus.wdata[7:4] == WDOS_SIGNATURE);
      if (i_bus.addr == WDOS_ADDR_GUARD_CTRL)
        ring_off <= (i_bus.wdata[7:4] == WDOS_SIGNATURE);
    end
  end
  sequence s_clr;
    i_bus.wr && i_bus.addr == WDOS_ADDR_BASE_CTRL && i_bus.wdata[1]
      ##1 i_bus.addr == WDOS_ADDR_BASE_COUNT;
  endsequence
  property p_wd_pulse; o_wd_reset |=> !o_wd_reset; endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("reset pulse too long");
  property p_wd_off; wd_off && $past(wd_off) |-> !o_wd_reset; endproperty
  a_wd_off: assert property (p_wd_off) else $error("reset while disabled");
  property p_ring_off; i_option_byte[7] && ring_off && sleep |-> !o_ring_osc_en; endproperty
  a_ring_off: assert property (p_ring_off) else $error("ring not stopped");
  property p_ring_on; !sleep |-> o_ring_osc_en; endproperty
  a_ring_on: assert property (p_ring_on) else $error("ring stopped while awake");
  property p_cpu_hold; $rose(i_reset_n) |-> !o_cpu_clock_en [*8]; endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("cpu clock early");
  property p_guard_lo; i_bus.addr == WDOS_ADDR_GUARD_CTRL |=> o_rdata[3:0] == 4'h0; endproperty
  a_guard_lo: assert property (p_guard_lo) else $error("guard nibble kept");
  property p_ctrl_self; i_bus.addr == WDOS_ADDR_BASE_CTRL |=> o_rdata[1:0] == 2'h0; endproperty
  a_ctrl_self: assert property (p_ctrl_self) else $error("clear bits kept");
  property p_clr; s_clr |=> o_rdata <= 8'h01; endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");
endmodule // wdos_core_sva
bind wdos_core wdos_core_sva i_sva (.i_clock, .i_reset_n, .i_bus, .i_option_byte,
  .i_stop_mode, .i_idle_mode, .o_rdata, .o_wd_reset, .o_cpu_clock_en, .o_ring_osc_en);

// [wdos_core_tb.sv]
// self-checking bench for wdos_core
// assumes the checker is bound by its own file
`timescale 1ns/1ps
module wdos_core_tb;
  import wdos_pkg::*;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
  localparam logic [7:0] BC = WDOS_ADDR_BASE_CTRL;
  localparam logic [7:0] GC = WDOS_ADDR_GUARD_CTRL;
  logic       i_clock, i_reset_n, i_ring_osc, i_stop_mode, i_idle_mode, i_ext_wake;
  wdos_bus_t  i_bus;
  logic [7:0] i_option_byte, o_rdata;
  logic       o_wd_reset, o_cpu_clock_en, o_ring_osc_en, o_base_overflow_tick;
  logic       ring_run;
  logic [2:0] rdiv = '0;
  int         bad_count = 0, cmp_count = 0, cyc = 0, t0, wd_cyc;
  int         wd_count = 0, ovf_count = 0, n0;
  assign i_ring_osc = rdiv[2];
  wdos_core i_dut (.i_clock, .i_reset_n, .i_bus, .i_option_byte, .i_ring_osc, .i_stop_mode,
    .i_idle_mode, .i_ext_wake, .o_rdata, .o_wd_reset, .o_cpu_clock_en, .o_ring_osc_en,
    .o_base_overflow_tick);
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // cycle count, ring source, reset capture, timeout
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    rdiv <= rdiv + {2'b00, ring_run};
    if (o_wd_reset)
    begin
      wd_count <= wd_count + 1;
      wd_cyc <= cyc;
    end
    if (o_base_overflow_tick)
      ovf_count <= ovf_count + 1;
    if (cyc == 90000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_bus <= '{w, a, d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    acc(1'b0, 8'h00, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    @(posedge i_clock);
    #1 `CHK("rdata", e, o_rdata)
  endtask
  task automatic wait_cpu(input int lim);
    while (!o_cpu_clock_en && cyc - t0 < lim)
    begin
      @(posedge i_clock);
      #1;
    end
  endtask
  initial
  begin
    i_reset_n = 1'b0;
    i_bus = '0;
    i_option_byte = 8'h80;
    {i_stop_mode, i_idle_mode, i_ext_wake, ring_run} = '0;
    repeat (8) @(posedge i_clock);
    i_reset_n <= 1'b1;
    t0 = cyc;
    rd(BC, 8'h00);
    rd(GC, 8'h00);
    rd(8'h10, 8'h00);
    wait_cpu(70000);
    `CHK("stab", 1'b1, (cyc - t0) inside {[65530:65545]})
    wr(BC, 8'h0c);
    rd(BC, 8'h0c);
    acc(1'b1, BC, 8'h0f);
    rd(WDOS_ADDR_BASE_COUNT, 8'h00);
    rd(BC, 8'h0c);
    ring_run = 1'b1;
    repeat (3)
    begin
      wr(GC, 8'h0a);
      t0 = cyc;
      repeat (1500) @(posedge i_clock);
    end
    `CHK("early", 0, wd_count)
    rd(GC, 8'h00);
    wr(GC, 8'h05);
    repeat (1000) @(posedge i_clock);
    `CHK("wd_count", 1, wd_count)
    `CHK("wd_len", 1'b1, (wd_cyc - t0) inside {[2030:2075]})
    wr(BC, 8'hac);
    n0 = wd_count;
    repeat (2600) @(posedge i_clock);
    `CHK("off", n0, wd_count)
    wr(BC, 8'hae);
    n0 = ovf_count;
    repeat (4000) @(posedge i_clock);
    `CHK("ovf_early", n0, ovf_count)
    repeat (200) @(posedge i_clock);
    `CHK("ovf_tick", n0 + 1, ovf_count)
    wr(GC, 8'ha0);
    i_idle_mode <= 1'b1;
    @(posedge i_clock);
    #1 `CHK("ring_idle", 1'b0, o_ring_osc_en)
    @(posedge i_clock);
    i_idle_mode <= 1'b0;
    i_stop_mode <= 1'b1;
    repeat (4) @(posedge i_clock);
    #1 `CHK("gated", 1'b0, o_cpu_clock_en)
    @(posedge i_clock);
    i_stop_mode <= 1'b0;
    i_ext_wake <= 1'b1;
    t0 = cyc;
    @(posedge i_clock);
    i_ext_wake <= 1'b0;
    wait_cpu(1000);
    `CHK("wake", 1'b1, (cyc - t0) inside {[236:264]})
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(BC, 8'h00);
    end_sim();
  end
endmodule // wdos_core_tb
